/* rtl/tmon_defs.svh */
// Register offsets, field positions, reset values and coding constants of the monitor
`ifndef TMON_DEFS_SVH
`define TMON_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TMON_ADDR_REMOTE1_READING 8'h25
`define TMON_ADDR_LOCAL_READING 8'h26
`define TMON_ADDR_REMOTE2_READING 8'h27
`define TMON_ADDR_STATUS 8'h41
`define TMON_ADDR_REMOTE1_LOW 8'h4e
`define TMON_ADDR_REMOTE1_HIGH 8'h4f
`define TMON_ADDR_LOCAL_LOW 8'h50
`define TMON_ADDR_LOCAL_HIGH 8'h51
`define TMON_ADDR_REMOTE2_LOW 8'h52
`define TMON_ADDR_REMOTE2_HIGH 8'h53
`define TMON_ADDR_REMOTE1_CORR 8'h70
`define TMON_ADDR_LOCAL_CORR 8'h71
`define TMON_ADDR_REMOTE2_CORR 8'h72
`define TMON_ADDR_MASK 8'h74
`define TMON_ADDR_FRACTION 8'h77
`define TMON_ADDR_CONFIG5 8'h7c
`define TMON_ADDR_ALERT_CFG 8'h7d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TMON_CFG5_COMPAT_BIT 0
`define TMON_CFG5_HALF_STEP_BIT 1
`define TMON_ALERT_SEL_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TMON_LOW_LIMIT_RESET 8'h81
`define TMON_HIGH_LIMIT_RESET 8'h7f
`define TMON_CORR_RESET 8'h00
`define TMON_READING_RESET 8'h00

// ----------------------------------------------------------------
// Result coding, in quarter degrees
// ----------------------------------------------------------------
`define TMON_TWOS_MIN_Q 12'shf04
`define TMON_TWOS_MAX_Q 12'sh1ff
`define TMON_BIAS_Q 12'sh100
`define TMON_EXT_MIN_Q 12'sh004
`define TMON_EXT_MAX_Q 12'sh3ff
`define TMON_FAULT_TWOS 8'h80
`define TMON_FAULT_EXT 8'h00
`define TMON_SIGN_FLIP 8'h80

`endif

/* rtl/tmon_pkg.sv */
// Types shared by the temperature result and limit logic
package tmon_pkg;

    typedef logic [1:0] tmon_chan_t;

    typedef enum logic [1:0] {
        TMON_REMOTE1,
        TMON_LOCAL,
        TMON_REMOTE2,
        TMON_NONE
    } tmon_chan_e;

    typedef struct packed {
        logic [2:0][7:0] reading;
        logic [2:0][1:0] lsbs;
        logic [2:0][7:0] low_lim;
        logic [2:0][7:0] high_lim;
        logic [2:0][7:0] corr;
        logic compat;
        logic half_step;
        logic alert_sel;
        logic [2:0] status;
        logic [2:0] mask;
        logic freeze;
        logic [2:0] pending;
        logic [7:0] rdata;
    } tmon_state_s;

endpackage

/* rtl/tmon_chan_if.sv */
// Signals between the register block and the per-conversion result path
`timescale 1ns/100ps
interface tmon_chan_if;
    logic signed [9:0] raw;
    logic fault;
    logic [7:0] corr;
    logic [7:0] low_lim;
    logic [7:0] high_lim;
    logic compat;
    logic half_step;
    logic [7:0] res_byte;
    logic [1:0] res_lsbs;
    logic out_of_limit;

    modport regs (
        output raw, fault, corr, low_lim, high_lim, compat, half_step,
        input res_byte, res_lsbs, out_of_limit
    );
    modport chan (
        input raw, fault, corr, low_lim, high_lim, compat, half_step,
        output res_byte, res_lsbs, out_of_limit
    );
endinterface

/* rtl/tmon_chan.sv */
// Correction, result coding and limit check of one conversion
`timescale 1ns/100ps
`include "tmon_defs.svh"
module tmon_chan (
    tmon_chan_if.chan cif
);
    import tmon_pkg::*;

    logic signed [11:0] raw_q;
    logic signed [11:0] corr_q;
    logic signed [11:0] sum_q;
    logic signed [11:0] coded_q;
    logic [7:0] cmp_res;
    logic [7:0] cmp_low;
    logic [7:0] cmp_high;

    // ----------------------------------------------------------------
    // Offset add and range coding
    // ----------------------------------------------------------------
    always_comb begin
        raw_q = {{2{cif.raw[9]}}, cif.raw};
        if (cif.half_step) begin
            corr_q = {{3{cif.corr[7]}}, cif.corr, 1'b0};
        end else begin
            corr_q = {{2{cif.corr[7]}}, cif.corr, 2'b00};
        end
        sum_q = raw_q + corr_q;
        if (cif.compat) begin
            if (sum_q < `TMON_TWOS_MIN_Q) begin
                coded_q = `TMON_TWOS_MIN_Q;
            end else if (sum_q > `TMON_TWOS_MAX_Q) begin
                coded_q = `TMON_TWOS_MAX_Q;
            end else begin
                coded_q = sum_q;
            end
        end else begin
            coded_q = sum_q + `TMON_BIAS_Q;
            if (coded_q < `TMON_EXT_MIN_Q) begin
                coded_q = `TMON_EXT_MIN_Q;
            end else if (coded_q > `TMON_EXT_MAX_Q) begin
                coded_q = `TMON_EXT_MAX_Q;
            end
        end
        if (cif.fault) begin
            cif.res_byte = cif.compat ? `TMON_FAULT_TWOS : `TMON_FAULT_EXT;
            cif.res_lsbs = 2'h0;
        end else begin
            cif.res_byte = coded_q[9:2];
            cif.res_lsbs = coded_q[1:0];
        end
    end

    // ----------------------------------------------------------------
    // Window compare, signed in compatible mode
    // ----------------------------------------------------------------
    always_comb begin
        cmp_res = cif.compat ? cif.res_byte ^ `TMON_SIGN_FLIP : cif.res_byte;
        cmp_low = cif.compat ? cif.low_lim ^ `TMON_SIGN_FLIP : cif.low_lim;
        cmp_high = cif.compat ? cif.high_lim ^ `TMON_SIGN_FLIP : cif.high_lim;
        cif.out_of_limit = (cmp_res > cmp_high) || (cmp_res <= cmp_low);
    end
endmodule

/* rtl/tmon_regs.sv */
// Temperature result, correction and limit registers with alert
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`include "tmon_defs.svh"
// What this block does
// - Add the channel's signed correction byte to every conversion before storing.
// - Three correction registers, remote 1, local, remote 2, reset to zero.
// - Configuration bit 1 sets correction step to one or half degree.
// - Configuration bit 0 stores all readings as twos complement up to 127.
// - In twos complement mode, values below minus 63 clamp to minus 63.
// - Diode fault reads 0x80 in twos complement, 0x00 in offset binary.
// - Fraction register holds two LSBs per channel, resets to zero.
// - Each channel has high and low limits setting its status bit.
// - Out-of-limit drives alert pin when unmasked and pin selected as alert.
// - Low limits reset to 0x81, high limits reset to 0x7F.
// - Each reading exists as whole degrees and as quarter-degree ten bits.
// - Whole-degree readings are valid whenever read, in any order.
// - Fraction read freezes readings until all three are read, then resumes.
// - Default coding is offset binary with bias 64; 0x40 is zero.
// - High check flags above limit, low check flags at or below.
module tmon_regs (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic conv_valid,
    input wire tmon_pkg::tmon_chan_t conv_chan,
    input wire logic signed [9:0] conv_data,
    input wire logic conv_fault,
    output logic irq,
    output logic alert_out,
    output logic alert_oe
);
    import tmon_pkg::*;

    localparam tmon_state_s RESET_STATE = '{
        reading: {3{`TMON_READING_RESET}},
        lsbs: '0,
        low_lim: {3{`TMON_LOW_LIMIT_RESET}},
        high_lim: {3{`TMON_HIGH_LIMIT_RESET}},
        corr: {3{`TMON_CORR_RESET}},
        compat: 1'b0,
        half_step: 1'b0,
        alert_sel: 1'b0,
        status: 3'h0,
        mask: 3'h0,
        freeze: 1'b0,
        pending: 3'h0,
        rdata: 8'h00
    };

    tmon_state_s st;
    tmon_state_s next_st;
    tmon_chan_if cif();
    logic [1:0] ch;
    logic conv_hit;
    logic frac_read;
    logic freeze_eff;

    // ----------------------------------------------------------------
    // Result path for the converting channel
    // ----------------------------------------------------------------
    tmon_chan u_chan (
        .cif(cif.chan)
    );

    always_comb begin
        case (conv_chan)
            TMON_REMOTE1: ch = 2'd0;
            TMON_LOCAL: ch = 2'd1;
            TMON_REMOTE2: ch = 2'd2;
            default: ch = 2'd0;
        endcase
    end

    assign conv_hit = conv_valid && (conv_chan != TMON_NONE);
    assign frac_read = rd_en && (addr == `TMON_ADDR_FRACTION);
    // Same-cycle fraction read already blocks the update
    assign freeze_eff = st.freeze || frac_read;

    assign cif.raw = conv_data;
    // The local sensor has no diode to fail
    assign cif.fault = conv_fault && (conv_chan != TMON_LOCAL);
    assign cif.corr = st.corr[ch];
    assign cif.low_lim = st.low_lim[ch];
    assign cif.high_lim = st.high_lim[ch];
    assign cif.compat = st.compat;
    assign cif.half_step = st.half_step;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rdata = 8'h00;

        if (rd_en) begin
            case (addr)
                `TMON_ADDR_REMOTE1_READING: begin
                    next_st.rdata = st.reading[0];
                    next_st.pending[0] = 1'b0;
                end
                `TMON_ADDR_LOCAL_READING: begin
                    next_st.rdata = st.reading[1];
                    next_st.pending[1] = 1'b0;
                end
                `TMON_ADDR_REMOTE2_READING: begin
                    next_st.rdata = st.reading[2];
                    next_st.pending[2] = 1'b0;
                end
                `TMON_ADDR_STATUS: begin
                    next_st.rdata = {5'h00, st.status};
                    next_st.status = 3'h0;
                end
                `TMON_ADDR_REMOTE1_LOW: next_st.rdata = st.low_lim[0];
                `TMON_ADDR_REMOTE1_HIGH: next_st.rdata = st.high_lim[0];
                `TMON_ADDR_LOCAL_LOW: next_st.rdata = st.low_lim[1];
                `TMON_ADDR_LOCAL_HIGH: next_st.rdata = st.high_lim[1];
                `TMON_ADDR_REMOTE2_LOW: next_st.rdata = st.low_lim[2];
                `TMON_ADDR_REMOTE2_HIGH: next_st.rdata = st.high_lim[2];
                `TMON_ADDR_REMOTE1_CORR: next_st.rdata = st.corr[0];
                `TMON_ADDR_LOCAL_CORR: next_st.rdata = st.corr[1];
                `TMON_ADDR_REMOTE2_CORR: next_st.rdata = st.corr[2];
                `TMON_ADDR_MASK: next_st.rdata = {5'h00, st.mask};
                `TMON_ADDR_FRACTION: begin
                    next_st.rdata = {st.lsbs[2], st.lsbs[1], st.lsbs[0], 2'b00};
                    next_st.freeze = 1'b1;
                    next_st.pending = 3'h7;
                end
                `TMON_ADDR_CONFIG5: begin
                    next_st.rdata = {6'h00, st.half_step, st.compat};
                end
                `TMON_ADDR_ALERT_CFG: next_st.rdata = {7'h00, st.alert_sel};
                default: next_st.rdata = 8'h00;
            endcase
            // Last outstanding reading read ends the freeze
            if (st.freeze && !frac_read && (next_st.pending == 3'h0)) begin
                next_st.freeze = 1'b0;
            end
        end

        if (wr_en) begin
            case (addr)
                `TMON_ADDR_REMOTE1_LOW: next_st.low_lim[0] = wdata;
                `TMON_ADDR_REMOTE1_HIGH: next_st.high_lim[0] = wdata;
                `TMON_ADDR_LOCAL_LOW: next_st.low_lim[1] = wdata;
                `TMON_ADDR_LOCAL_HIGH: next_st.high_lim[1] = wdata;
                `TMON_ADDR_REMOTE2_LOW: next_st.low_lim[2] = wdata;
                `TMON_ADDR_REMOTE2_HIGH: next_st.high_lim[2] = wdata;
                `TMON_ADDR_REMOTE1_CORR: next_st.corr[0] = wdata;
                `TMON_ADDR_LOCAL_CORR: next_st.corr[1] = wdata;
                `TMON_ADDR_REMOTE2_CORR: next_st.corr[2] = wdata;
                `TMON_ADDR_MASK: next_st.mask = wdata[2:0];
                `TMON_ADDR_CONFIG5: begin
                    next_st.compat = wdata[`TMON_CFG5_COMPAT_BIT];
                    next_st.half_step = wdata[`TMON_CFG5_HALF_STEP_BIT];
                end
                `TMON_ADDR_ALERT_CFG: next_st.alert_sel = wdata[`TMON_ALERT_SEL_BIT];
                default: next_st.alert_sel = st.alert_sel;
            endcase
        end

        // Conversion after the read so a new event beats the clear
        if (conv_hit) begin
            if (!freeze_eff) begin
                next_st.reading[ch] = cif.res_byte;
                next_st.lsbs[ch] = cif.res_lsbs;
            end
            if (cif.out_of_limit) begin
                next_st.status[ch] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rdata = st.rdata;
    assign irq = |(st.status & ~st.mask);
    assign alert_out = 1'b0;
    assign alert_oe = irq && st.alert_sel;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_limit_reset_val: assert property (
        $past(reset) |-> (st.low_lim == {3{8'h81}}) && (st.high_lim == {3{8'h7f}})
    ) else $error("limit registers not at reset value");

    a_corr_frac_reset: assert property (
        $past(reset) |-> (st.corr == '0) && (st.lsbs == '0)
    ) else $error("correction or fraction not zero after reset");

    a_freeze_start: assert property (
        frac_read |=> st.freeze && (st.pending == 3'h7)
    ) else $error("fraction read did not freeze readings");

    a_freeze_hold: assert property (
        st.freeze |=> $stable(st.reading) && $stable(st.lsbs)
    ) else $error("reading changed while frozen");

    a_freeze_release: assert property (
        (st.freeze && rd_en && addr == 8'h27 && st.pending == 3'h4) |=> !st.freeze
    ) else $error("freeze not released after last reading read");

    a_reading_update: assert property (
        (conv_valid && conv_chan == 2'd2 && !freeze_eff)
            |=> (st.reading[2] == $past(cif.res_byte))
            && (st.lsbs[2] == $past(cif.res_lsbs))
    ) else $error("remote 2 reading not updated");

    a_read_data: assert property (
        (rd_en && addr == 8'h26) |=> (rdata == $past(st.reading[1]))
            ##1 ($past(rd_en) || (rdata == 8'h00))
    ) else $error("local reading read data wrong");

    a_status_set: assert property (
        (conv_valid && conv_chan == 2'd1 && cif.out_of_limit) |=> st.status[1]
    ) else $error("status bit not set on out-of-limit");

    a_alert_gate: assert property (
        (conv_valid && conv_chan == 2'd0 && cif.out_of_limit && !st.mask[0]
            && st.alert_sel && !wr_en) |=> alert_oe && irq
    ) else $error("alert not raised for unmasked channel");

    a_fault_code: assert property (
        (conv_valid && conv_fault && conv_chan == 2'd0 && !freeze_eff)
            |=> st.reading[0] == ($past(st.compat) ? 8'h80 : 8'h00)
    ) else $error("diode fault code wrong");

    a_clamp_low: assert property (
        (conv_valid && !cif.fault && st.compat) |-> $signed(cif.res_byte) >= -8'sd63
    ) else $error("twos complement result below minus 63");

    a_zero_bias: assert property (
        (conv_valid && !cif.fault && !st.compat && conv_data == 10'sd0
            && cif.corr == 8'h00) |-> (cif.res_byte == 8'h40) && (cif.res_lsbs == 2'h0)
    ) else $error("offset binary zero not 0x40");

    a_limit_edges: assert property (
        (conv_valid && !st.compat && cif.res_byte == cif.low_lim) |-> cif.out_of_limit
    ) else $error("result equal to low limit not flagged");

    a_step_scale: assert property (
        (conv_valid && !cif.fault && !st.compat && st.half_step && conv_data == 10'sd0
            && cif.corr == 8'h02) |-> (cif.res_byte == 8'h41) && (cif.res_lsbs == 2'h0)
    ) else $error("half degree correction step wrong");

    a_full_step: assert property (
        (conv_valid && !cif.fault && !st.compat && !st.half_step && conv_data == 10'sd0
            && cif.corr == 8'h05) |-> (cif.res_byte == 8'h45)
    ) else $error("whole degree correction step wrong");

    a_ext_floor: assert property (
        (conv_valid && !cif.fault && !st.compat)
            |-> (cif.res_byte != 8'h00)
    ) else $error("offset binary result collides with fault code");

    a_fault_lsbs: assert property (
        (conv_valid && cif.fault)
            |-> (cif.res_lsbs == 2'h0)
    ) else $error("diode fault fraction not zero");

    a_high_flag: assert property (
        (conv_valid && !st.compat && cif.res_byte > cif.high_lim)
            |-> cif.out_of_limit
    ) else $error("result above high limit not flagged");

    a_inside_clear: assert property (
        (conv_valid && !st.compat && cif.res_byte > cif.low_lim
            && cif.res_byte <= cif.high_lim) |-> !cif.out_of_limit
    ) else $error("result inside limits flagged");

    // ----------------------------------------------------------------
    // Register port checks
    // ----------------------------------------------------------------
    a_status_clear: assert property (
        (rd_en && addr == 8'h41 && !conv_valid)
            |=> (st.status == 3'h0)
    ) else $error("status not cleared by read");

    a_status_sticky: assert property (
        (st.status[1] && !(rd_en && addr == 8'h41))
            |=> st.status[1]
    ) else $error("status bit lost without read");

    a_irq_masked: assert property (
        (st.mask[1] && st.status == 3'h2)
            |-> !irq
    ) else $error("masked status raised interrupt");

    a_alert_unsel: assert property (
        !st.alert_sel
            |-> !alert_oe
    ) else $error("alert driven while pin not selected");

    a_alert_follow: assert property (
        (st.alert_sel && st.status[0] && !st.mask[0])
            |-> alert_oe && !alert_out
    ) else $error("alert not driven low for unmasked status");

    a_frac_layout: assert property (
        (rd_en && addr == 8'h77)
            |=> (rdata[1:0] == 2'b00) && (rdata[7:6] == $past(st.lsbs[2]))
    ) else $error("fraction register layout wrong");

    a_corr_write: assert property (
        (wr_en && addr == 8'h70)
            |=> (st.corr[0] == $past(wdata))
    ) else $error("remote 1 correction write lost");

    a_limit_write: assert property (
        (wr_en && addr == 8'h51)
            |=> (st.high_lim[1] == $past(wdata))
    ) else $error("local high limit write lost");

    a_cfg_write: assert property (
        (wr_en && addr == 8'h7c)
            |=> ({6'h00, st.half_step, st.compat} == ($past(wdata) & 8'h03))
    ) else $error("configuration write lost");

    a_pending_clear: assert property (
        (st.freeze && rd_en && addr == 8'h25)
            |=> !st.pending[0]
    ) else $error("remote 1 read did not clear pending");
endmodule

/* verification/tmon_host.sv */
// Host model that drives the register port of the monitor
`timescale 1ns/100ps
module tmon_host (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr_en,
    output logic rd_en,
    input wire logic [7:0] rdata
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    // ----------------------------------------------------------------
    // Register cycles
    // ----------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        wdata <= ~d;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        addr <= ~a;
        // Data stand only in the cycle after the strobe
        @(negedge clk);
        d = rdata;
    endtask
endmodule

/* verification/tmon_regs_tb.sv */
// Self-checking bench of the monitor result, correction and limit registers
`timescale 1ns/100ps
`include "tmon_defs.svh"
module tmon_regs_tb;
    import tmon_pkg::*;
    typedef struct packed {
        logic [1:0] ch;
        logic [9:0] data;
        logic fault;
        logic [7:0] cfg;
        logic [7:0] corr;
        logic [7:0] byt;
        logic [1:0] lsb;
    } tmon_row_s;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [7:0] rdata;
    logic conv_valid = 1'b0;
    tmon_chan_t conv_chan = 2'h0;
    logic signed [9:0] conv_data = 10'h000;
    logic conv_fault = 1'b0;
    logic irq;
    logic alert_out;
    logic alert_oe;
    int fails = 0;
    int checked = 0;
    logic [7:0] rv;
    logic [7:0] fr;
    logic [7:0] rd [3];
    tmon_row_s rows [14] = '{
        '{2'h1, 10'h000, 1'b0, 8'h00, 8'h00, 8'h40, 2'h0},
        '{2'h0, 10'h029, 1'b0, 8'h00, 8'h00, 8'h4a, 2'h1},
        '{2'h2, 10'h000, 1'b0, 8'h00, 8'h05, 8'h45, 2'h0},
        '{2'h2, 10'h000, 1'b0, 8'h02, 8'h05, 8'h42, 2'h2},
        '{2'h2, 10'h000, 1'b0, 8'h02, 8'h02, 8'h41, 2'h0},
        '{2'h1, 10'h3fc, 1'b0, 8'h00, 8'hfe, 8'h3d, 2'h0},
        '{2'h0, 10'h066, 1'b0, 8'h01, 8'h00, 8'h19, 2'h2},
        '{2'h0, 10'h270, 1'b0, 8'h01, 8'h00, 8'hc1, 2'h0},
        '{2'h1, 10'h1ff, 1'b0, 8'h01, 8'h00, 8'h7f, 2'h3},
        '{2'h0, 10'h270, 1'b0, 8'h00, 8'h00, 8'h01, 2'h0},
        '{2'h2, 10'h1ff, 1'b0, 8'h00, 8'h00, 8'hbf, 2'h3},
        '{2'h0, 10'h000, 1'b1, 8'h01, 8'h00, 8'h80, 2'h0},
        '{2'h0, 10'h000, 1'b1, 8'h00, 8'h00, 8'h00, 2'h0},
        '{2'h1, 10'h000, 1'b1, 8'h00, 8'h00, 8'h40, 2'h0}
    };

    always #50 clk = ~clk;

    tmon_regs tmon_regs_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .conv_valid(conv_valid),
        .conv_chan(conv_chan), .conv_data(conv_data), .conv_fault(conv_fault),
        .irq(irq), .alert_out(alert_out), .alert_oe(alert_oe));
    tmon_host tmon_host_i (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic conv(input logic [1:0] ch, input logic [9:0] d, input logic f);
        @(posedge clk);
        conv_valid <= 1'b1;
        conv_chan <= ch;
        conv_data <= d;
        conv_fault <= f;
        @(posedge clk);
        conv_valid <= 1'b0;
        conv_data <= ~d;
    endtask

    task automatic lim_case(input logic [9:0] d, input logic [7:0] exp);
        conv(2'h1, d, 1'b0);
        tmon_host_i.rd_reg(`TMON_ADDR_STATUS, rv);
        chk("status", exp, rv);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #500000;
        fails++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            tmon_host_i.wr_reg(`TMON_ADDR_CONFIG5, rows[i].cfg);
            tmon_host_i.wr_reg(`TMON_ADDR_REMOTE1_CORR + {6'h00, rows[i].ch}, rows[i].corr);
            conv(rows[i].ch, rows[i].data, rows[i].fault);
            tmon_host_i.rd_reg(`TMON_ADDR_FRACTION, fr);
            for (int c = 0; c < 3; c++) begin
                tmon_host_i.rd_reg(`TMON_ADDR_REMOTE1_READING + 8'(c), rd[c]);
            end
            chk("reading", rows[i].byt, rd[rows[i].ch]);
            chk("fraction", {6'h00, rows[i].lsb}, {6'h00, fr[2 * rows[i].ch + 2 +: 2]});
        end
        $display("test coding done");
        conv(2'h1, 10'h000, 1'b0);
        tmon_host_i.rd_reg(`TMON_ADDR_FRACTION, rv);
        conv(2'h1, 10'h040, 1'b0);
        tmon_host_i.rd_reg(`TMON_ADDR_LOCAL_READING, rv);
        chk("frozen", 8'h40, rv);
        tmon_host_i.rd_reg(`TMON_ADDR_REMOTE1_READING, rv);
        conv(2'h1, 10'h040, 1'b0);
        tmon_host_i.rd_reg(`TMON_ADDR_LOCAL_READING, rv);
        chk("still frozen", 8'h40, rv);
        tmon_host_i.rd_reg(`TMON_ADDR_REMOTE2_READING, rv);
        conv(2'h1, 10'h040, 1'b0);
        tmon_host_i.rd_reg(`TMON_ADDR_LOCAL_READING, rv);
        chk("resumed", 8'h50, rv);
        $display("test freeze done");
        tmon_host_i.wr_reg(`TMON_ADDR_LOCAL_HIGH, 8'h50);
        tmon_host_i.wr_reg(`TMON_ADDR_LOCAL_LOW, 8'h30);
        tmon_host_i.rd_reg(`TMON_ADDR_STATUS, rv);
        lim_case(10'h040, 8'h00);
        lim_case(10'h044, 8'h02);
        lim_case(10'h3c0, 8'h02);
        lim_case(10'h3c4, 8'h00);
        tmon_host_i.wr_reg(`TMON_ADDR_MASK, 8'h02);
        conv(2'h1, 10'h044, 1'b0);
        @(negedge clk);
        chk("irq masked", 8'h00, {7'h00, irq});
        tmon_host_i.wr_reg(`TMON_ADDR_MASK, 8'h00);
        @(negedge clk);
        chk("irq", 8'h01, {7'h00, irq});
        chk("alert unselected", 8'h00, {7'h00, alert_oe});
        tmon_host_i.wr_reg(`TMON_ADDR_ALERT_CFG, 8'h01);
        @(negedge clk);
        chk("alert", 8'h02, {6'h00, alert_oe, alert_out});
        tmon_host_i.rd_reg(`TMON_ADDR_STATUS, rv);
        chk("status sticky", 8'h02, rv);
        chk("alert cleared", 8'h00, {6'h00, alert_oe, irq});
        conv(2'h0, 10'h000, 1'b0);
        @(negedge clk);
        chk("alert remote 1", 8'h03, {6'h00, alert_oe, irq});
        tmon_host_i.rd_reg(`TMON_ADDR_STATUS, rv);
        chk("status remote 1", 8'h01, rv);
        tmon_host_i.wr_reg(`TMON_ADDR_CONFIG5, 8'h01);
        tmon_host_i.wr_reg(`TMON_ADDR_LOCAL_HIGH, 8'h05);
        tmon_host_i.wr_reg(`TMON_ADDR_LOCAL_LOW, 8'hfb);
        lim_case(10'h3ec, 8'h02);
        lim_case(10'h3f0, 8'h00);
        lim_case(10'h014, 8'h00);
        lim_case(10'h018, 8'h02);
        tmon_host_i.wr_reg(`TMON_ADDR_REMOTE1_LOW, 8'h12);
        tmon_host_i.rd_reg(`TMON_ADDR_REMOTE1_LOW, rv);
        chk("limit write", 8'h12, rv);
        conv(2'h3, 10'h000, 1'b0);
        tmon_host_i.rd_reg(`TMON_ADDR_STATUS, rv);
        chk("channel 3 ignored", 8'h00, rv);
        $display("test limits done");
        @(posedge clk);
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (int a = 0; a < 6; a++) begin
            tmon_host_i.rd_reg(`TMON_ADDR_REMOTE1_LOW + 8'(a), rv);
            chk("limit reset", a[0] ? `TMON_HIGH_LIMIT_RESET : `TMON_LOW_LIMIT_RESET, rv);
        end
        for (int a = 0; a < 3; a++) begin
            tmon_host_i.rd_reg(`TMON_ADDR_REMOTE1_CORR + 8'(a), rv);
            chk("correction reset", `TMON_CORR_RESET, rv);
        end
        tmon_host_i.rd_reg(`TMON_ADDR_FRACTION, rv);
        chk("fraction reset", 8'h00, rv);
        tmon_host_i.wr_reg(`TMON_ADDR_LOCAL_READING, 8'h99);
        tmon_host_i.rd_reg(`TMON_ADDR_LOCAL_READING, rv);
        chk("reading read only", `TMON_READING_RESET, rv);
        tmon_host_i.rd_reg(8'h30, rv);
        chk("unmapped", 8'h00, rv);
        chk("irq reset", 8'h00, {6'h00, alert_oe, irq});
        $display("test reset done");
        end_sim();
    end
endmodule
